// ### rtl/spf_regs.sv
// AXI4-Lite register bank for speed-curve words 5/6 and fault-settings words
//
// Contract
// RQ1: Bit 30 of word 5 is the low bit of eight-bit speed point B.
// RQ2: Bits 6..0 of word 4 form point B's upper seven bits.
// RQ3: Word 5 bits 29..22 hold speed point C, code over 255.
// RQ4: Word 5 bits 21..14 hold speed point D, code over 255.
// RQ5: Word 5 bits 13..6 hold point E; bits 5..0 reserved, reset zero.
// RQ6: Word 6 bits 30..23 hold the second stop threshold.
// RQ7: Word 6 bits 22..15 hold second clamp threshold; bits 14..0 reserved.
// RQ8: Software leaves unlisted fault-settings offsets untouched.
// RQ9: Fault-settings word 1 at index 90h resets to zero.
// RQ10: Fault-settings word 2 at index 92h resets to zero.
// RQ11: Each word reads back exactly the last value written.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module spf_regs (
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite write address
    input wire logic [spf_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [spf_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [spf_pkg::STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [spf_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [spf_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Upper bits of speed point B from the word 4 register
    input wire logic [spf_pkg::SPEED_B_HI_W-1:0] speed_b_hi,
    // Stored fault-settings words
    output logic [spf_pkg::DATA_W-1:0] fault_settings_word1,
    output logic [spf_pkg::DATA_W-1:0] fault_settings_word2,
    // Unpacked speed-curve fields
    output logic [spf_pkg::SPEED_B_W-1:0] speed_b_code,
    output logic [spf_pkg::SPEED_CODE_W-1:0] speed_c_code,
    output logic [spf_pkg::SPEED_CODE_W-1:0] speed_d_code,
    output logic [spf_pkg::SPEED_CODE_W-1:0] speed_e_code,
    output logic [spf_pkg::SPEED_CODE_W-1:0] stop_threshold_two,
    output logic [spf_pkg::SPEED_CODE_W-1:0] clamp_threshold_two
);
    // Write channel states
    typedef enum logic [2:0] {
        SPF_WR_COLLECT = 3'b001,
        SPF_WR_COMMIT = 3'b010,
        SPF_WR_RESP = 3'b100
    } spf_wr_state_t;

    // Read channel states
    typedef enum logic [1:0] {
        SPF_RD_IDLE = 2'b01,
        SPF_RD_RESP = 2'b10
    } spf_rd_state_t;

    spf_wr_state_t wr_state_reg;
    spf_wr_state_t wr_state_next;
    spf_rd_state_t rd_state_reg;

    logic aw_got_reg;
    logic w_got_reg;
    logic [spf_pkg::IDX_W-1:0] aw_idx_reg;
    logic [spf_pkg::DATA_W-1:0] wdata_reg;
    logic [spf_pkg::STRB_W-1:0] wstrb_reg;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic commit;

    logic [spf_pkg::DATA_W-1:0] word5;
    logic [spf_pkg::DATA_W-1:0] word6;
    logic we_fault1;
    logic we_fault2;
    logic we_word5;
    logic we_word6;
    logic wr_hit;

    logic [spf_pkg::IDX_W-1:0] ar_idx;
    logic [spf_pkg::DATA_W-1:0] rd_value;
    logic rd_hit;

    // Channel handshakes
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign commit = (wr_state_reg == SPF_WR_COMMIT);

    // Write state sequencing
    always_comb begin
        wr_state_next = wr_state_reg;
        unique case (wr_state_reg)
            SPF_WR_COLLECT: begin
                if ((aw_got_reg || aw_hs) && (w_got_reg || w_hs)) begin
                    wr_state_next = SPF_WR_COMMIT;
                end
            end
            SPF_WR_COMMIT: begin
                wr_state_next = SPF_WR_RESP;
            end
            SPF_WR_RESP: begin
                if (s_axi_bready) begin
                    wr_state_next = SPF_WR_COLLECT;
                end
            end
            default: begin
                wr_state_next = SPF_WR_COLLECT;
            end
        endcase
    end

    // Write state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_state_reg <= SPF_WR_COLLECT;
        end else begin
            wr_state_reg <= wr_state_next;
        end
    end

    // Address capture; address and data may come in either order
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_reg <= 1'b0;
            aw_idx_reg <= 10'h000;
        end else if (aw_hs) begin
            aw_got_reg <= 1'b1;
            aw_idx_reg <= s_axi_awaddr[spf_pkg::ADDR_W-1:2];
        end else if (commit) begin
            aw_got_reg <= 1'b0;
        end
    end

    // Data capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_got_reg <= 1'b0;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else if (w_hs) begin
            w_got_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (commit) begin
            w_got_reg <= 1'b0;
        end
    end

    // Ready flags: open only while collecting and not yet taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= (wr_state_next == SPF_WR_COLLECT) && !(aw_got_reg || aw_hs);
            s_axi_wready <= (wr_state_next == SPF_WR_COLLECT) && !(w_got_reg || w_hs);
        end
    end

    // Write decode of the captured index
    always_comb begin
        we_fault1 = 1'b0;
        we_fault2 = 1'b0;
        we_word5 = 1'b0;
        we_word6 = 1'b0;
        wr_hit = 1'b1;
        unique case (aw_idx_reg)
            spf_pkg::IDX_FAULT_SETTINGS_WORD1: we_fault1 = commit;
            spf_pkg::IDX_FAULT_SETTINGS_WORD2: we_fault2 = commit;
            spf_pkg::IDX_SPEED_CURVE_WORD5: we_word5 = commit;
            spf_pkg::IDX_SPEED_CURVE_WORD6: we_word6 = commit;
            // RQ8: unlisted offsets ignored
            default: wr_hit = 1'b0;
        endcase
    end

    // Write response
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= spf_pkg::RESP_OKAY;
        end else if (commit) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? spf_pkg::RESP_OKAY : spf_pkg::RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // RQ9: fault word 1 zero reset
    spf_word #(
        .RESET_VALUE(spf_pkg::FAULT_SETTINGS_WORD1_RST)
    ) u_fault1 (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(we_fault1),
        .wr_strb(wstrb_reg),
        .wr_data(wdata_reg),
        .q(fault_settings_word1)
    );

    // RQ10: fault word 2 zero reset
    spf_word #(
        .RESET_VALUE(spf_pkg::FAULT_SETTINGS_WORD2_RST)
    ) u_fault2 (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(we_fault2),
        .wr_strb(wstrb_reg),
        .wr_data(wdata_reg),
        .q(fault_settings_word2)
    );

    // RQ5: word 5 storage, reserved bits reset zero
    spf_word #(
        .RESET_VALUE(spf_pkg::SPEED_CURVE_WORD5_RST)
    ) u_word5 (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(we_word5),
        .wr_strb(wstrb_reg),
        .wr_data(wdata_reg),
        .q(word5)
    );

    // RQ7: word 6 storage with reserved bits kept
    spf_word #(
        .RESET_VALUE(spf_pkg::SPEED_CURVE_WORD6_RST)
    ) u_word6 (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(we_word6),
        .wr_strb(wstrb_reg),
        .wr_data(wdata_reg),
        .q(word6)
    );

    // Field outputs derived from the stored words
    spf_speed_unpack u_unpack (
        .clk(clk),
        .rst_n(rst_n),
        .speed_b_hi(speed_b_hi),
        .word5(word5),
        .word6(word6),
        .speed_b_code(speed_b_code),
        .speed_c_code(speed_c_code),
        .speed_d_code(speed_d_code),
        .speed_e_code(speed_e_code),
        .stop_threshold_two(stop_threshold_two),
        .clamp_threshold_two(clamp_threshold_two)
    );

    // Read decode of the incoming index
    assign ar_idx = s_axi_araddr[spf_pkg::ADDR_W-1:2];

    // RQ11: full-word read back
    always_comb begin
        rd_value = 32'h00000000;
        rd_hit = 1'b1;
        unique case (ar_idx)
            spf_pkg::IDX_FAULT_SETTINGS_WORD1: rd_value = fault_settings_word1;
            spf_pkg::IDX_FAULT_SETTINGS_WORD2: rd_value = fault_settings_word2;
            spf_pkg::IDX_SPEED_CURVE_WORD5: rd_value = word5;
            spf_pkg::IDX_SPEED_CURVE_WORD6: rd_value = word6;
            default: rd_hit = 1'b0;
        endcase
    end

    // Read channel: take address, answer next cycle, hold until rready
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_state_reg <= SPF_RD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= spf_pkg::RESP_OKAY;
        end else begin
            unique case (rd_state_reg)
                SPF_RD_IDLE: begin
                    if (ar_hs) begin
                        rd_state_reg <= SPF_RD_RESP;
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rdata <= rd_value;
                        s_axi_rresp <= rd_hit ? spf_pkg::RESP_OKAY : spf_pkg::RESP_SLVERR;
                    end else begin
                        s_axi_arready <= 1'b1;
                    end
                end
                SPF_RD_RESP: begin
                    if (s_axi_rready) begin
                        rd_state_reg <= SPF_RD_IDLE;
                        s_axi_rvalid <= 1'b0;
                        s_axi_arready <= 1'b1;
                    end
                end
                default: begin
                    rd_state_reg <= SPF_RD_IDLE;
                end
            endcase
        end
    end
endmodule

// ### rtl/spf_pkg.sv
// Shared constants for the speed-curve and fault-settings register bank
package spf_pkg;
    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W = 10;
    localparam int STRB_W = 4;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_FAULT_SETTINGS_WORD1 = 10'h090;
    localparam logic [IDX_W-1:0] IDX_FAULT_SETTINGS_WORD2 = 10'h092;
    localparam logic [IDX_W-1:0] IDX_SPEED_CURVE_WORD5 = 10'h09c;
    localparam logic [IDX_W-1:0] IDX_SPEED_CURVE_WORD6 = 10'h09e;

    // Reset values
    localparam logic [DATA_W-1:0] FAULT_SETTINGS_WORD1_RST = 32'h00000000;
    localparam logic [DATA_W-1:0] FAULT_SETTINGS_WORD2_RST = 32'h00000000;
    localparam logic [DATA_W-1:0] SPEED_CURVE_WORD5_RST = 32'h00000000;
    localparam logic [DATA_W-1:0] SPEED_CURVE_WORD6_RST = 32'h00000000;

    // Field positions, common parity bit
    localparam int PARITY_POS = 31;
    // Word 5 fields
    localparam int SPEED_B_LSB_POS = 30;
    localparam int SPEED_C_MSB = 29;
    localparam int SPEED_C_LSB = 22;
    localparam int SPEED_D_MSB = 21;
    localparam int SPEED_D_LSB = 14;
    localparam int SPEED_E_MSB = 13;
    localparam int SPEED_E_LSB = 6;
    localparam int WORD5_RSV_MSB = 5;
    localparam int WORD5_RSV_LSB = 0;
    // Word 6 fields
    localparam int STOP_TWO_MSB = 30;
    localparam int STOP_TWO_LSB = 23;
    localparam int CLAMP_TWO_MSB = 22;
    localparam int CLAMP_TWO_LSB = 15;
    localparam int WORD6_RSV_MSB = 14;
    localparam int WORD6_RSV_LSB = 0;
    // Upper part of speed point B, held in the earlier word 4
    localparam int SPEED_B_HI_W = 7;
    localparam int SPEED_B_W = 8;
    localparam int SPEED_CODE_W = 8;
    // Full-scale divisor of every speed code
    localparam int SPEED_FULL_SCALE_CODE = 255;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ### rtl/spf_word.sv
// One 32-bit read/write register word with byte-lane strobes
`timescale 1ns/1ps
module spf_word #(
    parameter logic [31:0] RESET_VALUE = 32'h00000000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [spf_pkg::STRB_W-1:0] wr_strb,
    input wire logic [spf_pkg::DATA_W-1:0] wr_data,
    output logic [spf_pkg::DATA_W-1:0] q
);
    genvar b;
    generate
        for (b = 0; b < spf_pkg::STRB_W; b = b + 1) begin : g_lane
            logic [7:0] lane_reg;

            // Each enabled lane stores its byte, reserved bits included
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    lane_reg <= RESET_VALUE[b*8 +: 8];
                end else if (wr_en && wr_strb[b]) begin
                    lane_reg <= wr_data[b*8 +: 8];
                end
            end

            // Lane byte onto the word; one driver per lane slice
            assign q[b*8 +: 8] = lane_reg;
        end
    endgenerate
endmodule

// ### rtl/spf_speed_unpack.sv
// Registered unpacking of speed-curve fields from words 4, 5 and 6
`timescale 1ns/1ps
module spf_speed_unpack (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [spf_pkg::SPEED_B_HI_W-1:0] speed_b_hi,
    input wire logic [spf_pkg::DATA_W-1:0] word5,
    input wire logic [spf_pkg::DATA_W-1:0] word6,
    output logic [spf_pkg::SPEED_B_W-1:0] speed_b_code,
    output logic [spf_pkg::SPEED_CODE_W-1:0] speed_c_code,
    output logic [spf_pkg::SPEED_CODE_W-1:0] speed_d_code,
    output logic [spf_pkg::SPEED_CODE_W-1:0] speed_e_code,
    output logic [spf_pkg::SPEED_CODE_W-1:0] stop_threshold_two,
    output logic [spf_pkg::SPEED_CODE_W-1:0] clamp_threshold_two
);
    // Speed point B joins seven high bits with one low bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            speed_b_code <= 8'h00;
        end else begin
            // RQ1 RQ2: point B assembly
            speed_b_code <= {speed_b_hi, word5[spf_pkg::SPEED_B_LSB_POS]};
        end
    end

    // Points C, D and E of word 5
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            speed_c_code <= 8'h00;
            speed_d_code <= 8'h00;
            speed_e_code <= 8'h00;
        end else begin
            // RQ3: point C field
            speed_c_code <= word5[spf_pkg::SPEED_C_MSB:spf_pkg::SPEED_C_LSB];
            // RQ4: point D field
            speed_d_code <= word5[spf_pkg::SPEED_D_MSB:spf_pkg::SPEED_D_LSB];
            // RQ5: point E field
            speed_e_code <= word5[spf_pkg::SPEED_E_MSB:spf_pkg::SPEED_E_LSB];
        end
    end

    // Second stop and clamp thresholds of word 6
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_threshold_two <= 8'h00;
            clamp_threshold_two <= 8'h00;
        end else begin
            // RQ6: stop threshold field
            stop_threshold_two <= word6[spf_pkg::STOP_TWO_MSB:spf_pkg::STOP_TWO_LSB];
            // RQ7: clamp threshold field
            clamp_threshold_two <= word6[spf_pkg::CLAMP_TWO_MSB:spf_pkg::CLAMP_TWO_LSB];
        end
    end
endmodule

// ### test/spf_regs_assertions.sv
// Port-level checker for the speed-curve and fault-settings register bank
`timescale 1ns/1ps
module spf_regs_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [spf_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [spf_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [spf_pkg::SPEED_B_HI_W-1:0] speed_b_hi,
    input wire logic [spf_pkg::DATA_W-1:0] fault_settings_word1,
    input wire logic [spf_pkg::DATA_W-1:0] fault_settings_word2,
    input wire logic [spf_pkg::SPEED_B_W-1:0] speed_b_code,
    input wire logic [spf_pkg::SPEED_CODE_W-1:0] speed_c_code,
    input wire logic [spf_pkg::SPEED_CODE_W-1:0] speed_d_code,
    input wire logic [spf_pkg::SPEED_CODE_W-1:0] speed_e_code,
    input wire logic [spf_pkg::SPEED_CODE_W-1:0] stop_threshold_two,
    input wire logic [spf_pkg::SPEED_CODE_W-1:0] clamp_threshold_two
);
    logic [spf_pkg::IDX_W-1:0] rd_idx_reg;
    logic rd_ok;
    logic rd5;
    logic rd6;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Remembers which word the pending read addresses
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_idx_reg <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_idx_reg <= s_axi_araddr[11:2];
        end
    end

    // Accepted read beats of the two speed words
    assign rd_ok = s_axi_rvalid && s_axi_rready && (s_axi_rresp == spf_pkg::RESP_OKAY);
    assign rd5 = rd_ok && (rd_idx_reg == spf_pkg::IDX_SPEED_CURVE_WORD5);
    assign rd6 = rd_ok && (rd_idx_reg == spf_pkg::IDX_SPEED_CURVE_WORD6);

    // Write taken on both channels, answered two edges later
    sequence s_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_resp_late;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    a_write_resp_lag: assert property (s_both_taken |=> s_resp_late)
        else $error("write response timing wrong");
    a_point_b_low: assert property (rd5 |-> speed_b_code[0] == s_axi_rdata[30])
        else $error("point B low bit wrong");
    a_point_b_high: assert property (speed_b_code[7:1] == $past(speed_b_hi))
        else $error("point B upper bits wrong");
    a_point_c_field: assert property (rd5 |-> speed_c_code == s_axi_rdata[29:22])
        else $error("point C field wrong");
    a_point_d_field: assert property (rd5 |-> speed_d_code == s_axi_rdata[21:14])
        else $error("point D field wrong");
    a_point_e_field: assert property (rd5 |-> speed_e_code == s_axi_rdata[13:6])
        else $error("point E field wrong");
    a_stop_two_field: assert property (rd6 |-> stop_threshold_two == s_axi_rdata[30:23])
        else $error("stop threshold field wrong");
    a_clamp_two_field: assert property (rd6 |-> clamp_threshold_two == s_axi_rdata[22:15])
        else $error("clamp threshold field wrong");
    a_word1_reset: assert property ($rose(rst_n) |-> fault_settings_word1 == 32'h00000000)
        else $error("fault word 1 not cleared by reset");
    a_word2_reset: assert property ($rose(rst_n) |-> fault_settings_word2 == 32'h00000000)
        else $error("fault word 2 not cleared by reset");
endmodule

bind spf_regs spf_regs_assertions u_chk (.clk(clk), .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .speed_b_hi(speed_b_hi),
    .fault_settings_word1(fault_settings_word1), .fault_settings_word2(fault_settings_word2),
    .speed_b_code(speed_b_code), .speed_c_code(speed_c_code), .speed_d_code(speed_d_code),
    .speed_e_code(speed_e_code), .stop_threshold_two(stop_threshold_two),
    .clamp_threshold_two(clamp_threshold_two));

// ### test/tb_top.sv
// Self-checking bench for the speed-curve and fault-settings register bank
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic [11:0] s_axi_araddr = 12'h000;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [6:0] speed_b_hi = 7'h00;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, fault_settings_word1, fault_settings_word2;
    logic [7:0] speed_b_code;
    logic [7:0] speed_c_code, speed_d_code, speed_e_code, stop_threshold_two, clamp_threshold_two;
    int bad_count = 0;
    int compares = 0;

    // 50 MHz clock
    always #10 clk = ~clk;

    spf_regs dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .speed_b_hi(speed_b_hi),
        .fault_settings_word1(fault_settings_word1), .fault_settings_word2(fault_settings_word2),
        .speed_b_code(speed_b_code), .speed_c_code(speed_c_code), .speed_d_code(speed_d_code),
        .speed_e_code(speed_e_code), .stop_threshold_two(stop_threshold_two),
        .clamp_threshold_two(clamp_threshold_two));

    // Prints the counts and the verdict, then stops
    task automatic close_out();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Compares one value
    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    // A handshake that never came
    task automatic fail_wait();
        $display("unexpected handshake wait expected done seen timeout");
        bad_count++;
        close_out();
    endtask

    // One write; both channels offered together, each released when taken
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        int n;
        logic aw_pend;
        logic w_pend;
        aw_pend = 1'b1;
        w_pend = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50 && (aw_pend || w_pend); n++) begin
            @(posedge clk);
            if (aw_pend && s_axi_awready === 1'b1) begin
                aw_pend = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_pend && s_axi_wready === 1'b1) begin
                w_pend = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        if (aw_pend || w_pend) fail_wait();
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_bvalid === 1'b1) break;
        end
        if (n == 50) fail_wait();
        s_axi_bready <= 1'b0;
        check_val("bresp", 32'(er), 32'(s_axi_bresp));
        // Let an edge pass so the next call does not re-raise bready in this step
        @(posedge clk);
    endtask

    // One read, judged against the expected word and response
    task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) break;
        end
        if (n == 50) fail_wait();
        s_axi_arvalid <= 1'b0;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_rvalid === 1'b1) break;
        end
        if (n == 50) fail_wait();
        s_axi_rready <= 1'b0;
        check_val("rdata", ed, s_axi_rdata);
        check_val("rresp", 32'(er), 32'(s_axi_rresp));
        // Let an edge pass so the next call does not re-raise rready in this step
        @(posedge clk);
    endtask

    // All four words read zero after reset
    task automatic sc_reset_values();
        check_val("word1 port", 32'h00000000, fault_settings_word1);
        check_val("word2 port", 32'h00000000, fault_settings_word2);
        axi_read(12'h240, 32'h00000000, 2'b00);
        axi_read(12'h248, 32'h00000000, 2'b00);
        axi_read(12'h270, 32'h00000000, 2'b00);
        axi_read(12'h278, 32'h00000000, 2'b00);
    endtask

    // Speed word 5 fields with a pattern and its inverse
    task automatic sc_word5();
        logic [31:0] v;
        logic [6:0] hi;
        for (int i = 0; i < 2; i++) begin
            v = (i == 1) ? ~32'h6a5ac3e5 : 32'h6a5ac3e5;
            hi = (i == 1) ? 7'h25 : 7'h5a;
            speed_b_hi <= hi;
            axi_write(12'h270, v, 4'hf, 2'b00);
            axi_read(12'h270, v, 2'b00);
            check_val("speed_b_code", 32'({hi, v[30]}), 32'(speed_b_code));
            check_val("speed_c_code", 32'(v[29:22]), 32'(speed_c_code));
            check_val("speed_d_code", 32'(v[21:14]), 32'(speed_d_code));
            check_val("speed_e_code", 32'(v[13:6]), 32'(speed_e_code));
        end
    endtask

    // Speed word 6 thresholds and reserved bits
    task automatic sc_word6();
        logic [31:0] v;
        for (int i = 0; i < 2; i++) begin
            v = (i == 1) ? ~32'h4d5ba123 : 32'h4d5ba123;
            axi_write(12'h278, v, 4'hf, 2'b00);
            axi_read(12'h278, v, 2'b00);
            check_val("stop_threshold_two", 32'(v[30:23]), 32'(stop_threshold_two));
            check_val("clamp_threshold_two", 32'(v[22:15]), 32'(clamp_threshold_two));
        end
    endtask

    // Byte-lane strobes keep unselected bytes
    task automatic sc_strobes();
        axi_write(12'h240, 32'hffffffff, 4'hf, 2'b00);
        axi_write(12'h240, 32'h11223344, 4'h5, 2'b00);
        axi_read(12'h240, 32'hff22ff44, 2'b00);
        check_val("word1 port", 32'hff22ff44, fault_settings_word1);
        axi_write(12'h248, 32'h89abcdef, 4'hf, 2'b00);
        axi_write(12'h248, 32'h00000000, 4'ha, 2'b00);
        axi_read(12'h248, 32'h00ab00ef, 2'b00);
        check_val("word2 port", 32'h00ab00ef, fault_settings_word2);
    endtask

    // Unlisted slot between the two fault words is refused
    task automatic sc_unmapped();
        axi_write(12'h244, 32'hffffffff, 4'h0, 2'b10);
        check_val("word1 port", 32'hff22ff44, fault_settings_word1);
        check_val("word2 port", 32'h00ab00ef, fault_settings_word2);
        axi_read(12'h244, 32'h00000000, 2'b10);
    endtask

    // Reset in mid-run clears the stored words again
    task automatic sc_mid_reset();
        speed_b_hi <= 7'h00;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        check_val("word1 port", 32'h00000000, fault_settings_word1);
        check_val("word2 port", 32'h00000000, fault_settings_word2);
        rst_n <= 1'b1;
        @(posedge clk);
        axi_read(12'h240, 32'h00000000, 2'b00);
        axi_read(12'h248, 32'h00000000, 2'b00);
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        sc_reset_values();
        sc_word5();
        sc_word6();
        sc_strobes();
        sc_unmapped();
        sc_mid_reset();
        close_out();
    end
endmodule
